// ### hw/nvm_port_pkg.sv
package nvm_port_pkg;
  localparam int FLASH_AW = 14;
  localparam int EE_AW = 10;
  localparam int FW_BITS = 7;
  localparam int EW_BITS = 2;
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] FLASH_LAST = 15'h3FFF;
  localparam logic [CNT_W-1:0] EE_LAST = 15'h03FF;
  localparam logic [CNT_W-1:0] FPAGE_END = 15'h0080;
  localparam logic [CNT_W-1:0] EPAGE_END = 15'h0004;
  localparam logic [CNT_W-1:0] CFG_LAST = 15'h0003;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WFUSE = 8'h40;
  localparam logic [7:0] CMD_WLOCK = 8'h20;
  localparam logic [7:0] CMD_WFLASH = 8'h10;
  localparam logic [7:0] CMD_WEE = 8'h11;
  localparam logic [7:0] CMD_RSIG = 8'h08;
  localparam logic [7:0] CMD_RFUSE = 8'h04;
  localparam logic [7:0] CMD_RFLASH = 8'h02;
  localparam logic [7:0] CMD_REE = 8'h03;
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] BS_LOW = 2'h0;
  localparam logic [1:0] BS_HIGH = 2'h1;
  localparam logic [1:0] BS_EXT = 2'h2;
  localparam logic [1:0] BS_TOP = 2'h3;
  localparam logic [7:0] FUSE_LOW_RST = 8'h62;
  localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam int KEEP_EE_BIT = 3;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] SIG_ADDR0 = 16'h0000;
  localparam logic [15:0] SIG_ADDR1 = 16'h0001;
  localparam logic [15:0] SIG_ADDR2 = 16'h0002;
  localparam logic [3:0] PE_IDLE = 4'h0;
  localparam logic [2:0] TOGGLES_MIN = 3'h6;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ENTRY_GUARD_NS = 100;
  localparam int GUARD_CYC =
    (ENTRY_GUARD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [4:0] GUARD_LAST = 5'(GUARD_CYC - 1);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ERASE_FLASH, ST_ERASE_EE, ST_PROG_FLASH, ST_PROG_EE, ST_CFG
  } op_state_t;
  typedef enum logic [1:0] {
    EN_COUNT, EN_GUARD, EN_ACTIVE, EN_FAIL
  } entry_state_t;

  function automatic logic [7:0] pick_byte(logic [15:0] w, logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction : pick_byte
endpackage : nvm_port_pkg

// ### hw/nvm_store.sv
`timescale 1ns/1ps
// Simple dual-port array with registered read data.
module nvm_store #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : nvm_store

// ### hw/nvm_entry.sv
`timescale 1ns/1ps
// Watches the reset pin, the crystal input and the entry pins and decides
// whether the port enters programming mode.
module nvm_entry (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic high_voltage,
  input wire logic xtal_toggle,
  input wire logic [3:0] prog_enable,
  output logic prog_mode
);
  nvm_port_pkg::entry_state_t st_reg, st_next;
  logic [2:0] tog_reg, tog_next;
  logic [4:0] gcnt_reg, gcnt_next;

  always_comb begin
    st_next = st_reg;
    tog_next = tog_reg;
    gcnt_next = gcnt_reg;
    unique case (st_reg)
      nvm_port_pkg::EN_COUNT: begin
        if (high_voltage) begin
          gcnt_next = '0;
          if (tog_reg == nvm_port_pkg::TOGGLES_MIN &&
              prog_enable == nvm_port_pkg::PE_IDLE) begin
            st_next = nvm_port_pkg::EN_GUARD;
          end else begin
            st_next = nvm_port_pkg::EN_FAIL;
          end
        end else if (reset_pin_n) begin
          tog_next = '0;
        end else if (xtal_toggle && tog_reg != nvm_port_pkg::TOGGLES_MIN) begin
          tog_next = tog_reg + 3'h1;
        end
      end
      nvm_port_pkg::EN_GUARD: begin
        gcnt_next = gcnt_reg + 5'h01;
        if (!high_voltage) begin
          st_next = nvm_port_pkg::EN_COUNT;
        end else if (prog_enable != nvm_port_pkg::PE_IDLE) begin
          st_next = nvm_port_pkg::EN_FAIL;
        end else if (gcnt_reg == nvm_port_pkg::GUARD_LAST) begin
          st_next = nvm_port_pkg::EN_ACTIVE;
        end
      end
      nvm_port_pkg::EN_ACTIVE, nvm_port_pkg::EN_FAIL: begin
        if (!high_voltage) begin
          st_next = nvm_port_pkg::EN_COUNT;
          tog_next = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= nvm_port_pkg::EN_COUNT;
      tog_reg <= '0;
      gcnt_reg <= '0;
    end else begin
      st_reg <= st_next;
      tog_reg <= tog_next;
      gcnt_reg <= gcnt_next;
    end
  end

  assign prog_mode = (st_reg == nvm_port_pkg::EN_ACTIVE);

  entry_guard_a: assert property (@(posedge clk) disable iff (rst)
    (st_reg == nvm_port_pkg::EN_GUARD && high_voltage &&
     prog_enable != nvm_port_pkg::PE_IDLE) |=> !prog_mode [*3])
    else $error("Entry pins moved in the guard window yet mode entered.");

  entry_toggles_a: assert property (@(posedge clk) disable iff (rst)
    $rose(prog_mode) |-> $past(tog_reg, 1) == nvm_port_pkg::TOGGLES_MIN)
    else $error("Programming mode entered without six crystal toggles.");
endmodule : nvm_entry

// ### hw/nvm_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Fuses captured at mode entry; changes apply on exit, keep-eeprom at once.
// - Fuses are also captured once after power-up in normal mode.
// - Three identification bytes at signature addresses 0 to 2, always readable.
// - Calibration byte sits high at signature 0, loaded into trim on reset.
// - Flash pages hold 128 words; low seven address bits pick the word.
// - EEPROM pages hold four bytes; low two address bits pick the byte.
// - Ready-busy is low during an operation and high when ready.
// - Data bus is driven only while output enable is low.
// - Byte selects pick low, high or extended byte for loads and fuses.
// - Fuse read: 00 low, 01 lock, 10 extended, 11 fuse high.
// - Crystal strobe action: address, data, command, or nothing.
// - Write and output-enable pulses act on the last loaded command.
// - The nine command bytes are decoded exactly.
// - Entry pin activity within 100 ns of high voltage refuses entry.
// - Command and address stay loaded across operations.
// - Chip erase clears flash, EEPROM, locks; locks after flash erase.
// - With keep-eeprom programmed, chip erase spares the EEPROM.
// - Erase: load command, pulse write, busy until done.
// - Page latch pulse with byte select low high fills the page buffer.
// - Write pulse with selects 00 programs the page while busy.
module nvm_port #(
  parameter logic [7:0] SIG_BYTE0 = 8'hA5, // Arbitrary value.
  parameter logic [7:0] SIG_BYTE1 = 8'h5A, // Arbitrary value.
  parameter logic [7:0] SIG_BYTE2 = 8'h3C, // Arbitrary value.
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic high_voltage,
  input wire logic crystal_input_strobe,
  input wire logic strobe_action_1,
  input wire logic strobe_action_0,
  input wire logic byte_select_high,
  input wire logic byte_select_low,
  input wire logic page_latch,
  input wire logic write_n,
  input wire logic output_enable_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_busy_n,
  output logic prog_mode,
  output logic [7:0] fuse_low_active,
  output logic [7:0] fuse_high_active,
  output logic [7:0] fuse_ext_active,
  output logic [7:0] lock_bits,
  output logic keep_eeprom_on_erase,
  output logic [7:0] oscillator_trim_register
);
  nvm_port_pkg::op_state_t st_reg, st_next;
  logic [nvm_port_pkg::CNT_W-1:0] pf_len_reg, pf_len_next;
  logic [nvm_port_pkg::CNT_W-1:0] cnt_reg, cnt_next, cnt_m1;
  logic [7:0] cmd_reg, cmd_next, addr_lo_reg, addr_lo_next;
  logic [7:0] addr_hi_reg, addr_hi_next, addr_ex_reg, addr_ex_next;
  logic [7:0] dlo_reg, dlo_next, dhi_reg, dhi_next;
  logic [7:0] fl_reg, fl_next, fh_reg, fh_next, fe_reg, fe_next;
  logic [7:0] lock_reg, lock_next, dout_reg, dout_next;
  logic [7:0] fla_next, fha_next, fea_next;
  logic [7:0] trim_reg;
  logic cap_done_reg, mode_prev_reg;
  logic xtal_prev_reg, wr_prev_reg, pl_prev_reg;
  logic xtal_rise, wr_fall, pl_rise, idle, capture;
  logic [1:0] bs, act;
  logic [15:0] addr16, fl_wdata, fl_rdata, fb_rdata;
  logic [7:0] ee_wdata, ee_rdata, eb_rdata;
  logic fl_we, ee_we, fb_we, eb_we;
  logic [nvm_port_pkg::FLASH_AW-1:0] fl_waddr, flash_addr;
  logic [nvm_port_pkg::EE_AW-1:0] ee_waddr, ee_addr;

  assign bs = {byte_select_high, byte_select_low};
  assign act = {strobe_action_1, strobe_action_0};
  assign addr16 = {addr_hi_reg, addr_lo_reg};
  assign flash_addr = addr16[nvm_port_pkg::FLASH_AW-1:0];
  assign ee_addr = addr16[nvm_port_pkg::EE_AW-1:0];
  assign xtal_rise = crystal_input_strobe && !xtal_prev_reg;
  assign wr_fall = !write_n && wr_prev_reg;
  assign pl_rise = page_latch && !pl_prev_reg;
  assign idle = (st_reg == nvm_port_pkg::ST_IDLE);
  assign cnt_m1 = cnt_reg - nvm_port_pkg::CNT_ONE;
  assign capture = !cap_done_reg || (prog_mode != mode_prev_reg);

  nvm_entry entry_u (
    .clk(clk),
    .rst(rst),
    .reset_pin_n(reset_pin_n),
    .high_voltage(high_voltage),
    .xtal_toggle(crystal_input_strobe ^ xtal_prev_reg),
    .prog_enable({page_latch, strobe_action_1, strobe_action_0,
                  byte_select_low}),
    .prog_mode(prog_mode)
  );

  nvm_store #(.AW(nvm_port_pkg::FLASH_AW), .DW(16)) flash_u (
    .clk(clk), .we(fl_we), .waddr(fl_waddr), .wdata(fl_wdata),
    .raddr(flash_addr), .rdata(fl_rdata));
  nvm_store #(.AW(nvm_port_pkg::FW_BITS), .DW(16)) fbuf_u (
    .clk(clk), .we(fb_we), .waddr(flash_addr[nvm_port_pkg::FW_BITS-1:0]),
    .wdata({dhi_reg, dlo_reg}),
    .raddr(cnt_reg[nvm_port_pkg::FW_BITS-1:0]), .rdata(fb_rdata));
  nvm_store #(.AW(nvm_port_pkg::EE_AW), .DW(8)) eeprom_u (
    .clk(clk), .we(ee_we), .waddr(ee_waddr), .wdata(ee_wdata),
    .raddr(ee_addr), .rdata(ee_rdata));
  nvm_store #(.AW(nvm_port_pkg::EW_BITS), .DW(8)) ebuf_u (
    .clk(clk), .we(eb_we), .waddr(ee_addr[nvm_port_pkg::EW_BITS-1:0]),
    .wdata(dlo_reg), .raddr(cnt_reg[nvm_port_pkg::EW_BITS-1:0]),
    .rdata(eb_rdata));

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    addr_lo_next = addr_lo_reg;
    addr_hi_next = addr_hi_reg;
    addr_ex_next = addr_ex_reg;
    dlo_next = dlo_reg;
    dhi_next = dhi_reg;
    fl_next = fl_reg;
    fh_next = fh_reg;
    fe_next = fe_reg;
    lock_next = lock_reg;
    dout_next = dout_reg;
    fl_we = 1'b0;
    ee_we = 1'b0;
    fb_we = 1'b0;
    eb_we = 1'b0;
    fl_waddr = flash_addr;
    fl_wdata = nvm_port_pkg::ERASED_WORD;
    ee_waddr = ee_addr;
    ee_wdata = nvm_port_pkg::ERASED_BYTE;
    if (idle && prog_mode) begin
      if (xtal_rise) begin
        unique case (act)
          nvm_port_pkg::ACT_ADDR: begin
            unique case (bs)
              nvm_port_pkg::BS_LOW: addr_lo_next = data_in;
              nvm_port_pkg::BS_HIGH: addr_hi_next = data_in;
              nvm_port_pkg::BS_EXT: addr_ex_next = data_in;
              nvm_port_pkg::BS_TOP: ;
            endcase
          end
          nvm_port_pkg::ACT_DATA: begin
            if (!byte_select_high && byte_select_low) begin
              dhi_next = data_in;
            end else if (!byte_select_high) begin
              dlo_next = data_in;
            end
          end
          nvm_port_pkg::ACT_CMD: cmd_next = data_in;
          default: ;
        endcase
      end
      if (pl_rise && byte_select_low && cmd_reg == nvm_port_pkg::CMD_WFLASH) begin
        fb_we = 1'b1;
      end
      if (pl_rise && cmd_reg == nvm_port_pkg::CMD_WEE) begin
        eb_we = 1'b1;
      end
      if (wr_fall) begin
        cnt_next = '0;
        unique case (cmd_reg)
          nvm_port_pkg::CMD_ERASE: st_next = nvm_port_pkg::ST_ERASE_FLASH;
          nvm_port_pkg::CMD_WFUSE: begin
            unique case (bs)
              nvm_port_pkg::BS_LOW: fl_next = dlo_reg;
              nvm_port_pkg::BS_HIGH: fh_next = dlo_reg;
              nvm_port_pkg::BS_EXT: fe_next = dlo_reg;
              nvm_port_pkg::BS_TOP: ;
            endcase
            if (bs != nvm_port_pkg::BS_TOP) begin
              st_next = nvm_port_pkg::ST_CFG;
            end
          end
          nvm_port_pkg::CMD_WLOCK: begin
            lock_next = lock_reg & dlo_reg;
            st_next = nvm_port_pkg::ST_CFG;
          end
          nvm_port_pkg::CMD_WFLASH: begin
            if (bs == nvm_port_pkg::BS_LOW) begin
              st_next = nvm_port_pkg::ST_PROG_FLASH;
            end
          end
          nvm_port_pkg::CMD_WEE: begin
            if (bs == nvm_port_pkg::BS_LOW) begin
              st_next = nvm_port_pkg::ST_PROG_EE;
            end
          end
          default: ;
        endcase
      end
    end
    unique case (st_reg)
      nvm_port_pkg::ST_IDLE: ;
      nvm_port_pkg::ST_ERASE_FLASH: begin
        fl_we = 1'b1;
        fl_waddr = cnt_reg[nvm_port_pkg::FLASH_AW-1:0];
        cnt_next = cnt_reg + nvm_port_pkg::CNT_ONE;
        if (cnt_reg == nvm_port_pkg::FLASH_LAST) begin
          lock_next = nvm_port_pkg::LOCK_RST;
          cnt_next = '0;
          st_next = keep_eeprom_on_erase ? nvm_port_pkg::ST_IDLE :
                    nvm_port_pkg::ST_ERASE_EE;
        end
      end
      nvm_port_pkg::ST_ERASE_EE: begin
        ee_we = 1'b1;
        ee_waddr = cnt_reg[nvm_port_pkg::EE_AW-1:0];
        cnt_next = cnt_reg + nvm_port_pkg::CNT_ONE;
        if (cnt_reg == nvm_port_pkg::EE_LAST) begin
          st_next = nvm_port_pkg::ST_IDLE;
        end
      end
      nvm_port_pkg::ST_PROG_FLASH: begin
        // Buffer read is registered, so each write lags its read by one.
        fl_we = (cnt_reg != '0);
        fl_waddr = {flash_addr[nvm_port_pkg::FLASH_AW-1:nvm_port_pkg::FW_BITS],
                    cnt_m1[nvm_port_pkg::FW_BITS-1:0]};
        fl_wdata = fb_rdata;
        cnt_next = cnt_reg + nvm_port_pkg::CNT_ONE;
        if (cnt_reg == nvm_port_pkg::FPAGE_END) begin
          st_next = nvm_port_pkg::ST_IDLE;
        end
      end
      nvm_port_pkg::ST_PROG_EE: begin
        ee_we = (cnt_reg != '0);
        ee_waddr = {ee_addr[nvm_port_pkg::EE_AW-1:nvm_port_pkg::EW_BITS],
                    cnt_m1[nvm_port_pkg::EW_BITS-1:0]};
        ee_wdata = eb_rdata;
        cnt_next = cnt_reg + nvm_port_pkg::CNT_ONE;
        if (cnt_reg == nvm_port_pkg::EPAGE_END) begin
          st_next = nvm_port_pkg::ST_IDLE;
        end
      end
      nvm_port_pkg::ST_CFG: begin
        cnt_next = cnt_reg + nvm_port_pkg::CNT_ONE;
        if (cnt_reg == nvm_port_pkg::CFG_LAST) begin
          st_next = nvm_port_pkg::ST_IDLE;
        end
      end
      default: st_next = nvm_port_pkg::ST_IDLE;
    endcase
    if (!output_enable_n) begin
      unique case (cmd_reg)
        nvm_port_pkg::CMD_RFLASH: dout_next =
          nvm_port_pkg::pick_byte(fl_rdata, byte_select_low);
        nvm_port_pkg::CMD_REE: dout_next = ee_rdata;
        nvm_port_pkg::CMD_RFUSE: begin
          unique case (bs)
            nvm_port_pkg::BS_LOW: dout_next = fl_reg;
            nvm_port_pkg::BS_HIGH: dout_next = lock_reg;
            nvm_port_pkg::BS_EXT: dout_next = fe_reg;
            nvm_port_pkg::BS_TOP: dout_next = fh_reg;
          endcase
        end
        nvm_port_pkg::CMD_RSIG: begin
          if (addr16 == nvm_port_pkg::SIG_ADDR0) begin
            dout_next = nvm_port_pkg::pick_byte({CAL_BYTE, SIG_BYTE0},
                                                byte_select_low);
          end else if (addr16 == nvm_port_pkg::SIG_ADDR1) begin
            dout_next = SIG_BYTE1;
          end else if (addr16 == nvm_port_pkg::SIG_ADDR2) begin
            dout_next = SIG_BYTE2;
          end else begin
            dout_next = nvm_port_pkg::ERASED_BYTE;
          end
        end
        default: dout_next = nvm_port_pkg::ERASED_BYTE;
      endcase
    end
    fla_next = capture ? fl_reg : fuse_low_active;
    fha_next = capture ? fh_reg : fuse_high_active;
    fea_next = capture ? fe_reg : fuse_ext_active;
    // Counts the cycles of a flash page program so its length can be checked.
    pf_len_next = (st_reg == nvm_port_pkg::ST_PROG_FLASH) ?
                  pf_len_reg + nvm_port_pkg::CNT_ONE : '0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= nvm_port_pkg::ST_IDLE;
      cnt_reg <= '0;
      pf_len_reg <= '0;
      cmd_reg <= 8'h00;
      addr_lo_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      addr_ex_reg <= 8'h00;
      dlo_reg <= 8'h00;
      dhi_reg <= 8'h00;
      fl_reg <= nvm_port_pkg::FUSE_LOW_RST;
      fh_reg <= nvm_port_pkg::FUSE_HIGH_RST;
      fe_reg <= nvm_port_pkg::FUSE_EXT_RST;
      lock_reg <= nvm_port_pkg::LOCK_RST;
      dout_reg <= 8'h00;
      fuse_low_active <= nvm_port_pkg::FUSE_LOW_RST;
      fuse_high_active <= nvm_port_pkg::FUSE_HIGH_RST;
      fuse_ext_active <= nvm_port_pkg::FUSE_EXT_RST;
      trim_reg <= CAL_BYTE;
      cap_done_reg <= 1'b0;
      mode_prev_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b1;
      pl_prev_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      pf_len_reg <= pf_len_next;
      cmd_reg <= cmd_next;
      addr_lo_reg <= addr_lo_next;
      addr_hi_reg <= addr_hi_next;
      addr_ex_reg <= addr_ex_next;
      dlo_reg <= dlo_next;
      dhi_reg <= dhi_next;
      fl_reg <= fl_next;
      fh_reg <= fh_next;
      fe_reg <= fe_next;
      lock_reg <= lock_next;
      dout_reg <= dout_next;
      fuse_low_active <= fla_next;
      fuse_high_active <= fha_next;
      fuse_ext_active <= fea_next;
      trim_reg <= trim_reg;
      cap_done_reg <= 1'b1;
      mode_prev_reg <= prog_mode;
      xtal_prev_reg <= crystal_input_strobe;
      wr_prev_reg <= write_n;
      pl_prev_reg <= page_latch;
    end
  end

  assign data_out = dout_reg;
  assign data_oe = prog_mode && !output_enable_n;
  assign ready_busy_n = idle;
  assign lock_bits = lock_reg;
  assign keep_eeprom_on_erase = !fh_reg[nvm_port_pkg::KEEP_EE_BIT];
  assign oscillator_trim_register = trim_reg;

  erase_busy_a: assert property (@(posedge clk) disable iff (rst)
    (idle && prog_mode && wr_fall && cmd_reg == nvm_port_pkg::CMD_ERASE)
    |=> !ready_busy_n [*8])
    else $error("Chip erase did not hold ready-busy low.");
  page_time_a: assert property (@(posedge clk) disable iff (rst)
    (idle && $past(st_reg) == nvm_port_pkg::ST_PROG_FLASH)
    |-> pf_len_reg == nvm_port_pkg::FPAGE_END + nvm_port_pkg::CNT_ONE)
    else $error("Flash page program did not last 129 cycles.");
  bus_drive_a: assert property (@(posedge clk) disable iff (rst)
    data_oe |-> (!output_enable_n && prog_mode))
    else $error("Data bus driven without output enable.");
  lock_order_a: assert property (@(posedge clk) disable iff (rst)
    (lock_reg == nvm_port_pkg::LOCK_RST && $past(lock_reg) != lock_reg)
    |-> $past(st_reg) == nvm_port_pkg::ST_ERASE_FLASH)
    else $error("Lock bits cleared before flash erase finished.");
  fuse_hold_a: assert property (@(posedge clk) disable iff (rst)
    (prog_mode && $past(prog_mode) && $past(mode_prev_reg))
    |-> $stable(fuse_low_active) && $stable(fuse_high_active) &&
        $stable(fuse_ext_active))
    else $error("Active fuses changed inside programming mode.");
  bad_cmd_a: assert property (@(posedge clk) disable iff (rst)
    (idle && wr_fall && cmd_reg == 8'hFF) |=> ready_busy_n ##1 ready_busy_n)
    else $error("Unknown command made the port busy.");
  cmd_keep_a: assert property (@(posedge clk) disable iff (rst)
    (wr_fall && !(xtal_rise && act == nvm_port_pkg::ACT_CMD))
    |=> $stable(cmd_reg) && $stable(addr_lo_reg))
    else $error("Command or address lost across a write.");
  fuse_read_a: assert property (@(posedge clk) disable iff (rst)
    (!output_enable_n && cmd_reg == nvm_port_pkg::CMD_RFUSE &&
     bs == nvm_port_pkg::BS_HIGH) |=> data_out == $past(lock_reg))
    else $error("Lock bits not shown for byte selects 01.");
  trim_load_a: assert property (@(posedge clk) disable iff (rst)
    oscillator_trim_register == CAL_BYTE)
    else $error("Trim register lost the calibration byte.");
endmodule : nvm_port

// ### verification/pgm.sv
`timescale 1ns/1ps
module pgm (
  input wire logic clk,
  output logic reset_pin_n,
  output logic high_voltage,
  output logic crystal_input_strobe,
  output logic strobe_action_1,
  output logic strobe_action_0,
  output logic byte_select_high,
  output logic byte_select_low,
  output logic page_latch,
  output logic write_n,
  output logic output_enable_n,
  output logic [7:0] prog_data
);
  initial begin
    {reset_pin_n, write_n, output_enable_n} = 3'h7;
    {high_voltage, crystal_input_strobe, page_latch} = 3'h0;
    {strobe_action_1, strobe_action_0} = 2'h0;
    {byte_select_high, byte_select_low} = 2'h0;
    prog_data = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // Strobe, latch and write pulses last 50 cycles, which is 250 ns at 200 MHz.
  task automatic load(input logic [1:0] a, b, input logic [7:0] d);
    {strobe_action_1, strobe_action_0} = a;
    {byte_select_high, byte_select_low} = b;
    prog_data = d;
    hold(1);
    crystal_input_strobe = 1'b1;
    hold(50);
    crystal_input_strobe = 1'b0;
    hold(50);
  endtask : load
  task automatic latch();
    byte_select_low = 1'b1;
    page_latch = 1'b1;
    hold(50);
    page_latch = 1'b0;
    hold(50);
  endtask : latch
  task automatic wr(input logic [1:0] b);
    {byte_select_high, byte_select_low} = b;
    hold(1);
    write_n = 1'b0;
    hold(50);
    write_n = 1'b1;
    hold(2);
  endtask : wr
  task automatic oe(input logic v, input logic [1:0] b);
    {byte_select_high, byte_select_low} = b;
    output_enable_n = v;
    hold(3);
  endtask : oe
  task automatic enter(input logic glitch);
    reset_pin_n = 1'b0;
    repeat (6) begin
      load(2'h0, 2'h0, 8'h00);
    end
    hold(21);
    high_voltage = 1'b1;
    hold(5);
    page_latch = glitch;
    hold(50);
    page_latch = 1'b0;
  endtask : enter
  task automatic leave();
    high_voltage = 1'b0;
    reset_pin_n = 1'b1;
    hold(3);
  endtask : leave
endmodule : pgm

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] SIG [3] = '{8'h21, 8'h43, 8'h65}; // Arbitrary.
  localparam logic [7:0] CAL = 8'h7C;
  logic clk, rst, reset_pin_n, high_voltage, crystal_input_strobe;
  logic strobe_action_1, strobe_action_0, byte_select_high, byte_select_low;
  logic page_latch, write_n, output_enable_n, data_oe, ready_busy_n;
  logic prog_mode, keep_eeprom_on_erase;
  logic [7:0] prog_data, data_in, data_out, fuse_high_active, lock_bits;
  logic [7:0] oscillator_trim_register, fuse_low_active, fuse_ext_active;
  int n_mismatch = 0;
  int check_count = 0;
  // The device's drive wins the shared bus while it is enabled.
  assign data_in = data_oe ? data_out : prog_data;
  pgm u_pgm (.clk, .reset_pin_n, .high_voltage, .crystal_input_strobe,
    .strobe_action_1, .strobe_action_0, .byte_select_high, .byte_select_low,
    .page_latch, .write_n, .output_enable_n, .prog_data);
  nvm_port #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]),
    .CAL_BYTE(CAL)) u_nvm_port (.clk, .rst, .reset_pin_n, .high_voltage,
    .crystal_input_strobe, .strobe_action_1, .strobe_action_0,
    .byte_select_high, .byte_select_low, .page_latch, .write_n,
    .output_enable_n, .data_in, .data_out, .data_oe, .ready_busy_n,
    .prog_mode, .fuse_low_active, .fuse_high_active, .fuse_ext_active,
    .lock_bits, .keep_eeprom_on_erase, .oscillator_trim_register);
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_busy_n !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (ready_busy_n !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
  endtask : wait_ready
  task automatic rd(input logic [1:0] b, input logic [7:0] e);
    u_pgm.oe(1'b0, b);
    chk({7'h00, data_oe}, 8'h01);
    chk(data_out, e);
    u_pgm.oe(1'b1, b);
    chk({7'h00, data_oe}, 8'h00);
  endtask : rd
  task automatic sc_entry_sig();
    chk(oscillator_trim_register, CAL);
    chk(fuse_high_active, nvm_port_pkg::FUSE_HIGH_RST);
    u_pgm.enter(1'b0);
    chk({7'h00, prog_mode}, 8'h01);
    u_pgm.hold(10000);
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_RSIG);
    u_pgm.load(2'h0, 2'h1, 8'h00);
    for (int i = 0; i < 3; i++) begin
      u_pgm.load(2'h0, 2'h0, 8'(i));
      rd(2'h0, SIG[i]);
    end
    u_pgm.load(2'h0, 2'h0, 8'h00);
    rd(2'h1, CAL);
  endtask : sc_entry_sig
  task automatic sc_fuse_lock();
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_WFUSE);
    u_pgm.load(2'h1, 2'h0, 8'hF7);
    u_pgm.wr(2'h1);
    wait_ready();
    chk({7'h00, keep_eeprom_on_erase}, 8'h01);
    chk(fuse_high_active, nvm_port_pkg::FUSE_HIGH_RST);
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_WLOCK);
    u_pgm.load(2'h1, 2'h0, 8'hFC);
    u_pgm.wr(2'h0);
    wait_ready();
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_RFUSE);
    rd(2'h3, 8'hF7);
    rd(2'h1, 8'hFC);
    u_pgm.load(2'h2, 2'h0, 8'hFF);
    u_pgm.wr(2'h0);
    chk({7'h00, ready_busy_n}, 8'h01);
    chk(lock_bits, 8'hFC);
  endtask : sc_fuse_lock
  task automatic sc_erase_flash();
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_ERASE);
    u_pgm.wr(2'h0);
    chk({7'h00, ready_busy_n}, 8'h00);
    chk(lock_bits, 8'hFC);
    wait_ready();
    chk(lock_bits, 8'hFF);
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_WFLASH);
    u_pgm.load(2'h0, 2'h1, 8'h00);
    u_pgm.load(2'h0, 2'h0, 8'h85);
    u_pgm.load(2'h1, 2'h0, 8'h34);
    u_pgm.load(2'h1, 2'h1, 8'h12);
    u_pgm.latch();
    u_pgm.wr(2'h0);
    wait_ready();
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_RFLASH);
    rd(2'h0, 8'h34);
    rd(2'h1, 8'h12);
    u_pgm.load(2'h0, 2'h0, 8'h05);
    rd(2'h0, 8'hFF);
  endtask : sc_erase_flash
  task automatic sc_eeprom();
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_WEE);
    u_pgm.load(2'h1, 2'h0, 8'h5A);
    u_pgm.latch();
    u_pgm.wr(2'h0);
    wait_ready();
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_REE);
    rd(2'h0, 8'h5A);
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_ERASE);
    u_pgm.wr(2'h0);
    wait_ready();
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_REE);
    rd(2'h0, 8'h5A);
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_WFUSE);
    u_pgm.load(2'h1, 2'h0, 8'hFF);
    u_pgm.wr(2'h1);
    wait_ready();
    chk({7'h00, keep_eeprom_on_erase}, 8'h00);
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_ERASE);
    u_pgm.wr(2'h0);
    wait_ready();
    u_pgm.load(2'h2, 2'h0, nvm_port_pkg::CMD_REE);
    rd(2'h0, 8'hFF);
  endtask : sc_eeprom
  task automatic sc_exit_refuse();
    u_pgm.leave();
    chk({7'h00, prog_mode}, 8'h00);
    chk(fuse_high_active, 8'hFF);
    chk(fuse_low_active, nvm_port_pkg::FUSE_LOW_RST);
    chk(fuse_ext_active, nvm_port_pkg::FUSE_EXT_RST);
    u_pgm.enter(1'b1);
    chk({7'h00, prog_mode}, 8'h00);
    u_pgm.leave();
  endtask : sc_exit_refuse
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    sc_entry_sig();
    sc_fuse_lock();
    sc_erase_flash();
    sc_eeprom();
    sc_exit_refuse();
    test_done();
  end
endmodule : testbench
